// ==== hw/rspi_top.sv ====
// rate sensor serial slave port with enable, reload, ready and health pins
//
// Behaviour
// - slave only, serial clock idles low, data taken on rising edges.
// - data output is released (enable low) while slave select is high.
// - slave select is active low; the port answers only while it is low.
// - enable is active high; normal operation while high, pulled up outside.
// - reset pin low reloads calibration; pulled up outside, so idle high.
// - data-ready strobe each time a new rate sample becomes available.
// - health output is one while operating correctly, zero otherwise.
// - enable low enters power-down; rate updates, strobes and health stop; the buffer takes two samples, then stalls the source.
// - frame is one instruction byte then its instruction-specific arguments.
// - rate sample is 24-bit two's complement.
`timescale 1ns/1ps
module rspi_top #(
  parameter int CALIB_CYC = rspi_pkg::CALIB_CYC,
  parameter int DRY_CYC   = rspi_pkg::DRY_CYC
) (
  // core clock and reset
  input  wire logic                         core_clk_i,
  input  wire logic                         rst_n_i,
  // serial link
  input  wire logic                         spi_clk_i,
  input  wire logic                         slave_select_low_in_i,
  input  wire logic                         mosi_i,
  output logic                              miso_o,
  output logic                              miso_oe_o,
  // control and status pins
  input  wire logic                         enable_i,
  input  wire logic                         calib_reload_low_in_i,
  output logic                              new_sample_flag_out_o,
  output logic                              health_ok_out_o,
  output logic                              calib_reload_o,
  // measurement side
  input  wire logic [rspi_pkg::RATE_W-1:0]  sample_i,
  input  wire logic                         sample_valid_i,
  output logic                              sample_ready_o,
  input  wire logic [rspi_pkg::TEMP_W-1:0]  temp_i,
  input  wire logic                         drive_ok_i,
  // advanced command output
  output logic                              cmd_valid_o,
  output logic [rspi_pkg::INSTR_W-1:0]      cmd_instr_o,
  output logic [rspi_pkg::ARG_W-1:0]        cmd_arg_o
);

  localparam int CCW = $clog2(CALIB_CYC + 1);
  localparam int DCW = $clog2(DRY_CYC + 1);

  // ****************************************************************
  // link domain state
  // ****************************************************************
  logic [rspi_pkg::CNT_W-1:0]   cnt_q;
  logic [rspi_pkg::INSTR_W-1:0] rx_q;
  logic [rspi_pkg::WORD_W-1:0]  tx_q;
  logic [rspi_pkg::INSTR_W-1:0] instr_q;
  logic [rspi_pkg::ARG_W-1:0]   arg_q;
  logic [rspi_pkg::CNT_W-1:0]   bits_q;
  logic                         tog_q;
  logic [rspi_pkg::INSTR_W-1:0] instr_nx;
  logic [rspi_pkg::WORD_W-1:0]  reply;

  // ****************************************************************
  // core domain state
  // ****************************************************************
  logic                         ss_s;
  logic                         en_s;
  logic                         rl_n_s;
  logic                         tog_s;
  logic                         ss_prev_q;
  logic                         tog_seen_q;
  logic                         frame_end;
  logic [CCW-1:0]               calib_cnt_q;
  logic                         active;
  logic                         idle;
  logic [rspi_pkg::RATE_W-1:0]  buf_data;
  logic                         buf_valid;
  logic                         pop;
  logic [rspi_pkg::RATE_W-1:0]  rate_q;
  logic                         dry_q;
  logic                         rate_read;
  logic [DCW-1:0]               dry_cnt_q;
  logic [rspi_pkg::WORD_W-1:0]  pub_rate_q;
  logic [rspi_pkg::TEMP_W-1:0]  pub_temp_q;
  logic                         adv_done;

  // ****************************************************************
  // link: receive and count, cleared while deselected
  // ****************************************************************
  assign instr_nx = {rx_q[rspi_pkg::INSTR_W-2:0], mosi_i};

  // reply word for the instruction, read from idle-stable core registers
  always_comb begin
    reply = '0;
    if (instr_nx == rspi_pkg::INSTR_RATE) begin
      reply = pub_rate_q;
    end else if (instr_nx == rspi_pkg::INSTR_TEMP) begin
      reply[rspi_pkg::TEMP_LSB +: rspi_pkg::TEMP_W] = pub_temp_q;
    end
  end

  always_ff @(posedge spi_clk_i or posedge slave_select_low_in_i) begin
    if (slave_select_low_in_i) begin
      cnt_q <= '0;
      rx_q  <= '0;
      tx_q  <= '0;
    end else begin
      if (cnt_q != rspi_pkg::CNT_MAX) begin
        cnt_q <= cnt_q + 1'b1;
      end
      rx_q <= instr_nx;
      if (cnt_q == rspi_pkg::INSTR_LAST) begin
        tx_q <= reply;
      end else begin
        tx_q <= {tx_q[rspi_pkg::WORD_W-2:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // link: frame results, held after deselect for the core to read
  // ****************************************************************
  always_ff @(posedge spi_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      instr_q <= '0;
      arg_q   <= '0;
      bits_q  <= '0;
      tog_q   <= 1'b0;
    end else begin
      if (cnt_q != rspi_pkg::CNT_MAX) begin
        bits_q <= cnt_q + 1'b1;
      end
      if (cnt_q == '0) begin
        tog_q <= ~tog_q;
      end
      if (cnt_q == rspi_pkg::INSTR_LAST) begin
        instr_q <= instr_nx;
      end
      if (cnt_q > rspi_pkg::INSTR_LAST) begin
        arg_q <= {arg_q[rspi_pkg::ARG_W-2:0], mosi_i};
      end else if (cnt_q == '0) begin
        arg_q <= '0;
      end
    end
  end

  // ****************************************************************
  // link: output on falling edges, released while deselected
  // ****************************************************************
  always_ff @(negedge spi_clk_i or posedge slave_select_low_in_i) begin
    if (slave_select_low_in_i) begin
      miso_o    <= 1'b0;
      miso_oe_o <= 1'b0;
    end else begin
      miso_o    <= tx_q[rspi_pkg::WORD_W-1];
      miso_oe_o <= 1'b1;
    end
  end

  // ****************************************************************
  // pins into the core clock
  // ****************************************************************
  rspi_sync #(
    .W       (4),
    .RST_VAL (rspi_pkg::SYNC_RST)
  ) u_sync (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({slave_select_low_in_i, enable_i,
               calib_reload_low_in_i, tog_q}),
    .q_o     ({ss_s, en_s, rl_n_s, tog_s})
  );

  // a frame ends when select returns high after at least one clock
  assign frame_end = ss_s && !ss_prev_q && (tog_s != tog_seen_q);
  assign idle      = ss_s;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ss_prev_q  <= 1'b1;
      tog_seen_q <= 1'b0;
    end else begin
      ss_prev_q <= ss_s;
      if (ss_s) begin
        tog_seen_q <= tog_s;
      end
    end
  end

  // ****************************************************************
  // calibration reload, also run once after reset
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      calib_cnt_q    <= CCW'(CALIB_CYC);
      calib_reload_o <= 1'b1;
    end else begin
      if (!rl_n_s) begin
        calib_cnt_q <= CCW'(CALIB_CYC);
      end else if (calib_cnt_q != '0) begin
        calib_cnt_q <= calib_cnt_q - 1'b1;
      end
      calib_reload_o <= !rl_n_s || (calib_cnt_q > CCW'(1));
    end
  end

  // measuring only when enabled and not reloading
  assign active = en_s && !calib_reload_o;

  // ****************************************************************
  // sample stream; the buffer holds samples during frames and stalls the source once full
  // ****************************************************************
  rspi_buf #(
    .W     (rspi_pkg::RATE_W),
    .DEPTH (2)
  ) u_buf (
    .clk_i       (core_clk_i),
    .rst_n_i     (rst_n_i),
    .in_data_i   (sample_i),
    .in_valid_i  (sample_valid_i),
    .in_ready_o  (sample_ready_o),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (active && idle)
  );

  assign pop = buf_valid && active && idle;

  // ****************************************************************
  // current sample and its ready flag
  // ****************************************************************
  assign rate_read = frame_end
                     && (instr_q == rspi_pkg::INSTR_RATE)
                     && (bits_q >= rspi_pkg::frame_bits(instr_q));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_q <= '0;
    end else if (pop) begin
      rate_q <= buf_data;
    end
  end

  // a new sample in the cycle of a completed read keeps the flag set
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dry_q <= 1'b0;
    end else if (pop) begin
      dry_q <= 1'b1;
    end else if (rate_read) begin
      dry_q <= 1'b0;
    end
  end

  // ****************************************************************
  // data-ready strobe on the pin, DRY_CYC cycles wide
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dry_cnt_q             <= '0;
      new_sample_flag_out_o <= 1'b0;
    end else if (pop) begin
      dry_cnt_q             <= DCW'(DRY_CYC - 1);
      new_sample_flag_out_o <= 1'b1;
    end else if (dry_cnt_q != '0) begin
      dry_cnt_q <= dry_cnt_q - 1'b1;
    end else begin
      new_sample_flag_out_o <= 1'b0;
    end
  end

  // ****************************************************************
  // health status
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      health_ok_out_o <= 1'b0;
    end else begin
      health_ok_out_o <= active && drive_ok_i;
    end
  end

  // ****************************************************************
  // reply words, refreshed only while deselected
  // ****************************************************************
  // the link reads these at the eighth clock of a frame, long after
  // select falls, so they are stable when sampled
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pub_rate_q <= '0;
      pub_temp_q <= '0;
    end else if (idle) begin
      pub_rate_q <= '0;
      pub_rate_q[rspi_pkg::RATE_LSB +: rspi_pkg::RATE_W] <= rate_q;
      pub_rate_q[rspi_pkg::DRY_POS] <= dry_q;
      pub_rate_q[rspi_pkg::ST_POS]  <= health_ok_out_o;
      pub_temp_q <= temp_i;
    end
  end

  // ****************************************************************
  // advanced commands handed to the core
  // ****************************************************************
  assign adv_done = frame_end
                    && ((instr_q == rspi_pkg::INSTR_ADV_A)
                     || (instr_q == rspi_pkg::INSTR_ADV_B)
                     || (instr_q == rspi_pkg::INSTR_ADV_C))
                    && (bits_q >= rspi_pkg::frame_bits(instr_q));

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_instr_o <= '0;
      cmd_arg_o   <= '0;
    end else begin
      cmd_valid_o <= adv_done;
      if (adv_done) begin
        cmd_instr_o <= instr_q;
        cmd_arg_o   <= arg_q;
      end
    end
  end

endmodule

// ==== hw/rspi_pkg.sv ====
// constants and helpers shared by the rate sensor serial port design
package rspi_pkg;

  // ****************************************************************
  // clock, widths and timing
  // ****************************************************************
  localparam int CLK_NS        = 25;
  localparam int INSTR_W       = 8;
  localparam int RATE_W        = 24;
  localparam int TEMP_W        = 14;
  localparam int WORD_W        = 32;
  localparam int ARG_W         = 64;
  localparam int CNT_W         = 7;
  localparam int CALIB_NS      = 1000;
  localparam int CALIB_CYC     = (CALIB_NS + CLK_NS - 1) / CLK_NS;
  localparam int DRY_NS        = 250;
  localparam int DRY_CYC       = (DRY_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // instruction codes and frame layout
  // ****************************************************************
  localparam logic [INSTR_W-1:0] INSTR_RATE  = 8'h50;
  localparam logic [INSTR_W-1:0] INSTR_TEMP  = 8'h54;
  localparam logic [INSTR_W-1:0] INSTR_ADV_A = 8'h58;
  localparam logic [INSTR_W-1:0] INSTR_ADV_B = 8'h78;
  localparam logic [INSTR_W-1:0] INSTR_ADV_C = 8'h7C;
  localparam logic [CNT_W-1:0]   INSTR_LAST  = 7'h07;
  localparam logic [CNT_W-1:0]   CNT_MAX     = 7'h7F;
  localparam int RATE_LSB      = 8;
  localparam int DRY_POS       = 1;
  localparam int ST_POS        = 0;
  localparam int TEMP_LSB      = 18;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [3:0] SYNC_RST = 4'hE;

  // argument bytes that follow each instruction, zero if unknown
  function automatic logic [3:0] arg_bytes(input logic [INSTR_W-1:0] op);
    unique case (op)
      INSTR_RATE, INSTR_ADV_A: arg_bytes = 4'h4;
      INSTR_TEMP, INSTR_ADV_C: arg_bytes = 4'h2;
      INSTR_ADV_B:             arg_bytes = 4'h8;
      default:                 arg_bytes = 4'h0;
    endcase
  endfunction

  // serial clocks needed to complete a frame for the instruction
  function automatic logic [CNT_W-1:0] frame_bits(
      input logic [INSTR_W-1:0] op);
    frame_bits = INSTR_LAST + 7'h01 + {arg_bytes(op), 3'h0};
  endfunction

endpackage

// ==== hw/rspi_sync.sv ====
// two flip-flop synchroniser for a bundle of independent levels
`timescale 1ns/1ps
module rspi_sync #(
  parameter int         W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // levels
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule

// ==== hw/rspi_buf.sv ====
// two-entry sample buffer with valid and ready on both sides
`timescale 1ns/1ps
module rspi_buf #(
  parameter int W     = 24,
  parameter int DEPTH = 2
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // fill side
  input  wire logic [W-1:0] in_data_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  // drain side
  output logic      [W-1:0] out_data_o,
  output logic              out_valid_o,
  input  wire logic         out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q      <= '0;
      in_ready_o <= 1'b1;
      wr_q       <= '0;
      rd_q       <= '0;
    end else begin
      cnt_q      <= cnt_d;
      in_ready_o <= (cnt_d != FULL);
      if (push) begin
        wr_q <= next_ptr(wr_q);
      end
      if (pop) begin
        rd_q <= next_ptr(rd_q);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

endmodule

// ==== bench/rspi_properties.sv ====
// checker for the rate sensor serial port pins
`timescale 1ns/1ps
module rspi_properties #(
  parameter int DRY_CYC = 2
) (
  // clock and reset
  input wire logic                         core_clk_i,
  input wire logic                         rst_n_i,
  // serial link
  input wire logic                         slave_select_low_in_i,
  input wire logic                         miso_oe_o,
  // control and status pins
  input wire logic                         enable_i,
  input wire logic                         calib_reload_low_in_i,
  input wire logic                         new_sample_flag_out_o,
  input wire logic                         health_ok_out_o,
  input wire logic                         calib_reload_o,
  input wire logic                         drive_ok_i,
  // command output
  input wire logic                         cmd_valid_o,
  input wire logic [rspi_pkg::INSTR_W-1:0] cmd_instr_o,
  input wire logic [rspi_pkg::ARG_W-1:0]   cmd_arg_o
);
  logic [7:0] flag_len_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // length of the current data-ready strobe
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_len_q <= 8'h00;
    end else if (new_sample_flag_out_o) begin
      flag_len_q <= flag_len_q + 8'h01;
    end else begin
      flag_len_q <= 8'h00;
    end
  end

  sequence s_pdown; (!enable_i) [*5]; endsequence
  sequence s_reload; calib_reload_o [*2]; endsequence
  sequence s_good; (enable_i && drive_ok_i && !calib_reload_o) [*6]; endsequence

  property p_released; slave_select_low_in_i |-> !miso_oe_o; endproperty
  a_released: assert property (p_released)
    else $error("data output driven while deselected");
  property p_drive_sel; $rose(miso_oe_o) |-> !slave_select_low_in_i; endproperty
  a_drive_sel: assert property (p_drive_sel)
    else $error("data output enabled without select");
  property p_run; s_good |-> health_ok_out_o; endproperty
  a_run: assert property (p_run)
    else $error("health low in normal operation");
  property p_pdown_health; s_pdown |-> !health_ok_out_o; endproperty
  a_pdown_health: assert property (p_pdown_health)
    else $error("health high in power-down");
  property p_pdown_flag; s_pdown |-> !$rose(new_sample_flag_out_o); endproperty
  a_pdown_flag: assert property (p_pdown_flag)
    else $error("data-ready strobe in power-down");
  property p_bad_drive; !drive_ok_i |=> !health_ok_out_o; endproperty
  a_bad_drive: assert property (p_bad_drive)
    else $error("health high with failing drive");
  property p_reload_go; $fell(calib_reload_low_in_i) |-> ##[1:4] calib_reload_o;
  endproperty
  a_reload_go: assert property (p_reload_go)
    else $error("reload not started");
  property p_reload_hl; s_reload |-> !health_ok_out_o; endproperty
  a_reload_hl: assert property (p_reload_hl)
    else $error("health high during reload");
  property p_flag_w; $fell(new_sample_flag_out_o) |-> flag_len_q >= DRY_CYC;
  endproperty
  a_flag_w: assert property (p_flag_w)
    else $error("data-ready strobe too short");
  property p_cmd; cmd_valid_o |=> !cmd_valid_o && $stable(cmd_arg_o)
    && $stable(cmd_instr_o); endproperty
  a_cmd: assert property (p_cmd)
    else $error("command strobe not single or not held");
endmodule

bind rspi_top rspi_properties #(.DRY_CYC(DRY_CYC)) chk_u (
  .core_clk_i, .rst_n_i, .slave_select_low_in_i, .miso_oe_o, .enable_i,
  .calib_reload_low_in_i, .new_sample_flag_out_o, .health_ok_out_o,
  .calib_reload_o, .drive_ok_i, .cmd_valid_o, .cmd_instr_o, .cmd_arg_o
);

// ==== bench/rspi_host.sv ====
// host serial master model issuing mode 0 frames
`timescale 1ns/1ps
module rspi_host (
  // serial lines
  output logic      sclk_o,
  output logic      slave_select_low_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  logic pat_q = 1'b0;
  logic line;

  // released line shows a toggling pattern, never the last bit
  assign line = miso_oe_i ? miso_i : pat_q;

  // lines start low as when unpowered; select then rises to clear the port
  initial begin
    sclk_o = 1'b0;
    slave_select_low_o = 1'b0;
    mosi_o = 1'b0;
    #1;
    slave_select_low_o = 1'b1;
  end

  // instruction byte first, reply bits collected after it
  task automatic xfer(input logic [71:0] tx, input int nbits,
                      output logic [63:0] rx);
    rx = '0;
    slave_select_low_o = 1'b0;
    #32;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = tx[71-i];
      #16;
      sclk_o = 1'b1;
      if (i >= 8) rx = {rx[62:0], line};
      pat_q = ~pat_q;
      #16;
      sclk_o = 1'b0;
    end
    #32;
    slave_select_low_o = 1'b1;
    mosi_o = 1'b0;
  endtask
endmodule

// ==== bench/rspi_top_tb.sv ====
// self-checking bench for the rate sensor serial port
`timescale 1ns/1ps
module rspi_top_tb;
  localparam int CALIB = 4;
  localparam int NEW_SAMPLE_FLAG_OUT   = 2;

  logic        core_clk_i = 1'b0;
  logic        rst_n_i    = 1'b1;
  logic        spi_clk_i, slave_select_low_in_i, mosi_i, miso_o, miso_oe_o;
  logic        enable_i, calib_reload_low_in_i, new_sample_flag_out_o;
  logic        health_ok_out_o, calib_reload_o, sample_valid_i, got;
  logic        sample_ready_o, drive_ok_i, cmd_valid_o;
  logic [23:0] sample_i;
  logic [13:0] temp_i;
  logic [7:0]  cmd_instr_o;
  logic [63:0] cmd_arg_o, rx;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          cycles     = 0;

  always #12.5 core_clk_i = ~core_clk_i;

  rspi_top #(.CALIB_CYC(CALIB), .DRY_CYC(NEW_SAMPLE_FLAG_OUT)) dut_u (
    .core_clk_i, .rst_n_i, .spi_clk_i, .slave_select_low_in_i, .mosi_i,
    .miso_o, .miso_oe_o, .enable_i, .calib_reload_low_in_i,
    .new_sample_flag_out_o, .health_ok_out_o, .calib_reload_o, .sample_i,
    .sample_valid_i, .sample_ready_o, .temp_i, .drive_ok_i, .cmd_valid_o,
    .cmd_instr_o, .cmd_arg_o
  );
  rspi_host host_u (
    .sclk_o(spi_clk_i), .slave_select_low_o(slave_select_low_in_i),
    .mosi_o(mosi_i), .miso_i(miso_o), .miso_oe_i(miso_oe_o)
  );

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic nclk(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic push(input logic [23:0] s);
    @(posedge core_clk_i);
    sample_i <= s;
    sample_valid_i <= 1'b1;
    do @(posedge core_clk_i); while (sample_ready_o !== 1'b1);
    sample_valid_i <= 1'b0;
  endtask

  // one frame, then watch for the command strobe
  task automatic frame(input logic [7:0] op, input int nb,
                       input logic [63:0] arg, input int bits);
    logic [71:0] tx;
    tx = {op, 64'h0} | ({8'h0, arg} << (64 - 8 * nb));
    host_u.xfer(tx, bits, rx);
    got = 1'b0;
    repeat (12) begin
      @(negedge core_clk_i);
      if (cmd_valid_o === 1'b1) got = 1'b1;
    end
  endtask

  task automatic t_reset();
    repeat (6) @(posedge core_clk_i);
    @(negedge core_clk_i);
    check("reload in reset", 64'(calib_reload_o), 64'h1);
    check("ready in reset", 64'(sample_ready_o), 64'h1);
    check("flag in reset", 64'(new_sample_flag_out_o), 64'h0);
    check("health in reset", 64'(health_ok_out_o), 64'h0);
    check("oe idle", 64'(miso_oe_o), 64'h0);
    @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (int n = 0; n < 60 && calib_reload_o !== 1'b0; n++) nclk(1);
    nclk(4);
    check("health after reload", 64'(health_ok_out_o), 64'h1);
    $display("test reset done");
  endtask

  task automatic t_rate();
    logic [23:0] s [2] = '{24'h800000, 24'h7FFFFF};
    foreach (s[i]) begin
      push(s[i]);
      for (int n = 0; n < 20 && new_sample_flag_out_o !== 1'b1; n++) nclk(1);
      nclk(NEW_SAMPLE_FLAG_OUT - 1);
      check("flag held", 64'(new_sample_flag_out_o), 64'h1);
      nclk(1);
      check("flag end", 64'(new_sample_flag_out_o), 64'h0);
      frame(8'h50, 4, 64'h0, 40);
      check("rate word", 64'(rx[31:8]), 64'(s[i]));
      check("rate status", 64'(rx[7:0]), 64'h03);
      frame(8'h50, 4, 64'h0, 40);
      check("status reread", 64'(rx[7:0]), 64'h01);
    end
    $display("test rate done");
  endtask

  task automatic t_temp();
    @(posedge core_clk_i);
    temp_i <= 14'h2A5C;
    nclk(4);
    frame(8'h54, 2, 64'h0, 24);
    check("temp reply", 64'(rx[15:0]), 64'({14'h2A5C, 2'b00}));
    $display("test temperature done");
  endtask

  task automatic t_cmd();
    logic [7:0] op [3] = '{8'h58, 8'h78, 8'h7C};
    int nb [3] = '{4, 8, 2};
    logic [63:0] a;
    foreach (op[i]) begin
      a = 64'h0123456789ABCDEF >> (64 - 8 * nb[i]);
      frame(op[i], nb[i], a, 8 + 8 * nb[i]);
      check("cmd strobe", 64'(got), 64'h1);
      check("cmd instr", 64'(cmd_instr_o), 64'(op[i]));
      check("cmd arg", cmd_arg_o, a);
    end
    frame(8'h33, 2, 64'h1234, 24);
    check("unknown strobe", 64'(got), 64'h0);
    check("unknown reply", rx, 64'h0);
    frame(8'h7C, 2, 64'hBEEF, 16);
    check("short strobe", 64'(got), 64'h0);
    check("instr kept", 64'(cmd_instr_o), 64'h7C);
    $display("test commands done");
  endtask

  task automatic t_pdown();
    int acc = 0;
    logic [23:0] last;
    @(posedge core_clk_i);
    enable_i <= 1'b0;
    nclk(6);
    check("health off", 64'(health_ok_out_o), 64'h0);
    @(posedge core_clk_i);
    sample_i <= 24'h00ABCD;
    sample_valid_i <= 1'b1;
    repeat (8) begin
      @(negedge core_clk_i);
      if (sample_ready_o === 1'b1) begin
        acc++;
        last = sample_i;
      end
      @(posedge core_clk_i);
      sample_i <= sample_i + 24'h1;
    end
    sample_valid_i <= 1'b0;
    check("held words", 64'(acc), 64'h2);
    check("no strobe", 64'(new_sample_flag_out_o), 64'h0);
    @(posedge core_clk_i);
    enable_i <= 1'b1;
    nclk(20);
    check("drained", 64'(sample_ready_o), 64'h1);
    frame(8'h50, 4, 64'h0, 40);
    check("last word", 64'(rx[31:8]), 64'(last));
    $display("test power-down done");
  endtask

  task automatic t_reload();
    @(posedge core_clk_i);
    calib_reload_low_in_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    calib_reload_low_in_i <= 1'b1;
    for (int n = 0; n < 8 && calib_reload_o !== 1'b1; n++) nclk(1);
    check("reload start", 64'(calib_reload_o), 64'h1);
    nclk(2);
    check("health in reload", 64'(health_ok_out_o), 64'h0);
    for (int n = 0; n < 60 && calib_reload_o !== 1'b0; n++) nclk(1);
    nclk(4);
    check("health back", 64'(health_ok_out_o), 64'h1);
    @(posedge core_clk_i);
    drive_ok_i <= 1'b0;
    nclk(3);
    check("health bad drive", 64'(health_ok_out_o), 64'h0);
    $display("test reload done");
  endtask

  // the falling edge at time zero lets every rst_n_i reset act; the select-cleared link state waits for the host
  initial begin
    rst_n_i <= 1'b0;
    enable_i = 1'b1;
    calib_reload_low_in_i = 1'b1;
    sample_i = 24'h0;
    sample_valid_i = 1'b0;
    temp_i = 14'h0;
    drive_ok_i = 1'b1;
    t_reset();
    t_rate();
    t_temp();
    t_cmd();
    t_pdown();
    t_reload();
    end_of_test();
  end
endmodule
